// >>> inc/pd_odt_defs.svh
// Timing counts, command bits and field codes for power-down and termination control
`ifndef PD_ODT_DEFS_SVH
`define PD_ODT_DEFS_SVH

`define REF_CLK_MHZ          200
// Receivers go quiet after two no-operation cycles
`define RX_SHUTDOWN_CYCLES   2
// Exit latency in ns; the real figure comes from the part's AC table
`define PD_EXIT_LATENCY_NS   8
`define PD_EXIT_CYCLES       ((`PD_EXIT_LATENCY_NS * `REF_CLK_MHZ + 999) / 1000)
// Termination drop leads the read latency point by this many cycles
`define READ_OFF_LEAD        2
`define TERM_CODE_OFF        2'h0
// Deep power-down command bit levels with chip select low
`define DEEP_CA0             1'h1
`define DEEP_CA1             1'h1
`define DEEP_CA2             1'h0

`endif

// >>> inc/pd_odt_pkg.sv
// Types shared by the power-down and termination control logic
package pd_odt_pkg;

  typedef enum logic [2:0] {
    RUN,
    IDLE_PD,
    ACTIVE_PD,
    DEEP_SLEEP,
    PD_EXIT
  } pd_state_type;

endpackage

// >>> rtl/dram_powerdown_odt_control.sv
// Power-down, deep power-down and on-die termination control of the memory device
// Function
// [R1] Write leveling: strobe termination follows pin, data termination stays off.
// [R2] Writes enable both terminations; reads, calibrations, address training disable both.
// [R3] Termination needs non-zero setting code and pin high.
// [R4] Read drops termination from read latency minus two.
// [R5] Read restores termination at read latency plus half burst.
// [R6] Clock enable low with select high enters power-down; next cycle no-operation.
// [R7] Controller keeps clock enable high during reads, writes, register accesses.
// [R8] Entry disables buffers; receivers stop after entry delay; two no-operations follow.
// [R9] Controller holds clock enable low for the minimum pulse time.
// [R10] No refresh during power-down; controller limits its duration.
// [R11] Exit by clock enable high with select high, held minimum time.
// [R12] Commands accepted only after exit latency from clock enable rise.
// [R13] All banks idle gives idle power-down, else active power-down.
// [R14] Controller supplies two stable clock cycles before exit.
// [R15] After read, clock enable low no earlier than latency plus burst plus one.
// [R16] After write, clock enable low after latency, burst and write recovery.
// [R17] Write with auto precharge adds one more cycle before power-down.
// [R18] After refresh, activate, precharge: clock enable low after hold time.
// [R19] After mode register write, wait write cycle time before power-down.
// [R20] Clock enable low, select low, command bits 110 enters deep power-down.
// [R21] Deep power-down needs idle banks, quiet bus; contents are lost.
// [R22] Leaving deep power-down requires full initialization before use.
// [R23] Power-down termination bit zero disables termination during power-down.
// [R24] Termination off during self refresh and deep power-down.
// [R25] Deep power-down exits when clock enable registered high.
// [R26] In power-down states, address inputs ignored; only clock enable rise counts.
`include "pd_odt_defs.svh"

module dram_powerdown_odt_control #(
  parameter int BURST_LENGTH = 8
) (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       clock_enable,
  input  wire logic       chip_select_n,
  input  wire logic [9:0] command_address,
  input  wire logic       termination_control_pin,
  input  wire logic [1:0] termination_setting_register,
  input  wire logic       pd_termination_enable,
  input  wire logic [5:0] read_latency,
  input  wire logic       read_issued,
  input  wire logic       write_leveling_mode,
  input  wire logic       read_dq_cal_active,
  input  wire logic       zq_cal_active,
  input  wire logic       ca_training_mode,
  input  wire logic       self_refresh_active,
  input  wire logic       banks_idle,
  input  wire logic       init_done,
  output logic            dq_term_en,
  output logic            dqs_term_en,
  output logic            io_buffers_on,
  output logic            receivers_on,
  output logic            refresh_allowed,
  output logic            cmd_ready,
  output logic            active_power_down,
  output logic            deep_sleep_state,
  output logic            init_required
);

  pd_odt_pkg::pd_state_type state;
  logic       clock_enable_q;
  logic       term_s1;
  logic       term_s2;
  logic       term_s3;
  logic       term_level;
  logic [7:0] rd_cnt;
  logic       rd_busy;
  logic [7:0] rd_start;
  logic [7:0] rd_end;
  logic       read_off;
  logic [1:0] rx_cnt;
  logic [3:0] exit_cnt;
  logic       in_pd;
  logic       cke_fall;
  logic       pd_entry;
  logic       deep_entry;
  logic       term_allow;

  localparam logic [3:0] EXIT_CYCLES = 4'(`PD_EXIT_CYCLES);
  localparam logic [1:0] RX_CYCLES   = 2'(`RX_SHUTDOWN_CYCLES);

  // Previous clock enable, to see a registered fall
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clock_enable_q <= 1'h1;
    end else begin
      clock_enable_q <= clock_enable;
    end
  end

  // Termination pin is asynchronous; accept a change once stages two and three agree
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      term_s1    <= 1'h0;
      term_s2    <= 1'h0;
      term_s3    <= 1'h0;
      term_level <= 1'h0;
    end else begin
      term_s1 <= termination_control_pin;
      term_s2 <= term_s1;
      term_s3 <= term_s2;
      if (term_s2 == term_s3) begin
        term_level <= term_s3;
      end
    end
  end

  // Entry decode, only while running: power-down states ignore address inputs
  assign in_pd     = (state == pd_odt_pkg::IDLE_PD) || (state == pd_odt_pkg::ACTIVE_PD);
  assign cke_fall  = (state == pd_odt_pkg::RUN) && clock_enable_q && !clock_enable;
  assign pd_entry  = cke_fall && chip_select_n; // R6
  assign deep_entry = cke_fall && !chip_select_n && (command_address[0] == `DEEP_CA0)
                      && (command_address[1] == `DEEP_CA1)
                      && (command_address[2] == `DEEP_CA2); // R20

  // Power state sequencing
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state    <= pd_odt_pkg::RUN;
      exit_cnt <= 4'h0;
    end else begin
      case (state)
        pd_odt_pkg::RUN: begin
          if (pd_entry) begin
            state <= banks_idle ? pd_odt_pkg::IDLE_PD : pd_odt_pkg::ACTIVE_PD; // R13
          end else if (deep_entry) begin
            state <= pd_odt_pkg::DEEP_SLEEP; // R21
          end
        end
        pd_odt_pkg::IDLE_PD, pd_odt_pkg::ACTIVE_PD: begin
          // Only a rise of clock enable matters here
          if (clock_enable) begin // R26
            if (EXIT_CYCLES > 4'h1) begin
              state    <= pd_odt_pkg::PD_EXIT;
              exit_cnt <= EXIT_CYCLES - 4'h2; // R12
            end else begin
              state <= pd_odt_pkg::RUN;
            end
          end
        end
        pd_odt_pkg::PD_EXIT: begin
          if (exit_cnt == 4'h0) begin
            state <= pd_odt_pkg::RUN; // R12
          end else begin
            exit_cnt <= exit_cnt - 4'h1;
          end
        end
        pd_odt_pkg::DEEP_SLEEP: begin
          if (clock_enable) begin
            state <= pd_odt_pkg::RUN; // R25
          end
        end
        default: begin
          state <= pd_odt_pkg::RUN;
        end
      endcase
    end
  end

  // Contents lost in deep sleep; stays flagged until initialization completes
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      init_required <= 1'h0;
    end else if (state == pd_odt_pkg::DEEP_SLEEP) begin
      init_required <= 1'h1; // R22
    end else if (init_done) begin
      init_required <= 1'h0;
    end
  end

  // Receiver shutdown delay after entry, counted while powered down
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_cnt <= 2'h0;
    end else if (pd_entry || deep_entry) begin
      rx_cnt <= 2'h0;
    end else if ((in_pd || deep_sleep_state) && (rx_cnt < RX_CYCLES)) begin
      rx_cnt <= rx_cnt + 2'h1; // R8
    end
  end

  // Status views of the power state
  assign io_buffers_on     = !(in_pd || deep_sleep_state); // R8
  assign receivers_on      = io_buffers_on || (rx_cnt < RX_CYCLES); // R8
  assign refresh_allowed   = !(in_pd || deep_sleep_state); // R10
  assign cmd_ready         = (state == pd_odt_pkg::RUN);
  assign active_power_down = (state == pd_odt_pkg::ACTIVE_PD); // R13
  assign deep_sleep_state  = (state == pd_odt_pkg::DEEP_SLEEP);

  // Read window bounds; a read latency below the lead clamps to zero
  assign rd_start = (read_latency > 6'(`READ_OFF_LEAD))
                    ? {2'h0, read_latency - 6'(`READ_OFF_LEAD)} : 8'h00;
  assign rd_end   = {2'h0, read_latency} + 8'(BURST_LENGTH / 2);

  // Cycle count since the latest read; a new read restarts the window
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_busy <= 1'h0;
      rd_cnt  <= 8'h00;
    end else if (read_issued) begin
      rd_busy <= 1'h1;
      rd_cnt  <= 8'h00;
    end else if (rd_busy) begin
      if (rd_cnt >= rd_end) begin
        rd_busy <= 1'h0; // R5
      end else begin
        rd_cnt <= rd_cnt + 8'h01;
      end
    end
  end

  // Output register adds a cycle, so the window is looked up one count early
  assign read_off = (read_issued && (rd_start == 8'h00)) // R4
                    || (rd_busy && ((rd_cnt + 8'h01) >= rd_start)
                        && ((rd_cnt + 8'h01) < rd_end)); // R4 R5

  // Conditions that must all hold to open termination, pin level included
  assign term_allow = (termination_setting_register != `TERM_CODE_OFF) && term_level // R3
                      && !read_off && !read_dq_cal_active && !zq_cal_active // R2
                      && !ca_training_mode // R2
                      && !self_refresh_active && !deep_sleep_state // R24
                      && !(in_pd && !pd_termination_enable); // R23

  // Registered enables; write leveling keeps data lines unterminated
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dqs_term_en <= 1'h0;
      dq_term_en  <= 1'h0;
    end else begin
      dqs_term_en <= term_allow; // R1
      dq_term_en  <= term_allow && !write_leveling_mode; // R1
    end
  end

  property p_wl_dq_off; // R1
    @(posedge ref_clk) disable iff (sys_rst)
      write_leveling_mode |=> !dq_term_en;
  endproperty
  a_wl_dq_off: assert property (p_wl_dq_off) else $error("data termination on in leveling");

  property p_train_off; // R2
    @(posedge ref_clk) disable iff (sys_rst)
      (ca_training_mode || zq_cal_active) |=> !dqs_term_en && !dq_term_en;
  endproperty
  a_train_off: assert property (p_train_off) else $error("termination on during training");

  property p_code_zero; // R3
    @(posedge ref_clk) disable iff (sys_rst)
      (termination_setting_register == `TERM_CODE_OFF || !term_level) |=> !dqs_term_en;
  endproperty
  a_code_zero: assert property (p_code_zero) else $error("termination on with code zero");

  property p_read_window; // R4
    @(posedge ref_clk) disable iff (sys_rst)
      (rd_busy && (rd_cnt + 8'h01) >= rd_start && (rd_cnt + 8'h01) < rd_end)
      |=> !dqs_term_en && !dq_term_en;
  endproperty
  a_read_window: assert property (p_read_window) else $error("termination on in read window");

  property p_pd_entry; // R6
    @(posedge ref_clk) disable iff (sys_rst)
      (state == pd_odt_pkg::RUN && $past(clock_enable) && !clock_enable && chip_select_n)
      |=> !io_buffers_on && !refresh_allowed;
  endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("power-down not entered");

  property p_rx_delay; // R8
    @(posedge ref_clk) disable iff (sys_rst)
      pd_entry |=> receivers_on ##1 (receivers_on || clock_enable);
  endproperty
  a_rx_delay: assert property (p_rx_delay) else $error("receivers stopped too early");

  property p_exit_latency; // R12
    @(posedge ref_clk) disable iff (sys_rst)
      (in_pd && clock_enable) |=> !cmd_ready ##1 cmd_ready;
  endproperty
  a_exit_latency: assert property (p_exit_latency) else $error("exit latency wrong");

  property p_deep_entry; // R20
    @(posedge ref_clk) disable iff (sys_rst)
      deep_entry |=> deep_sleep_state ##1 (init_required && !dqs_term_en);
  endproperty
  a_deep_entry: assert property (p_deep_entry) else $error("deep sleep not entered");

  property p_pd_term; // R23
    @(posedge ref_clk) disable iff (sys_rst)
      (in_pd && !pd_termination_enable) |=> !dqs_term_en;
  endproperty
  a_pd_term: assert property (p_pd_term) else $error("termination on in power-down");

  property p_deep_exit; // R25
    @(posedge ref_clk) disable iff (sys_rst)
      (deep_sleep_state && clock_enable) |=> cmd_ready && init_required;
  endproperty
  a_deep_exit: assert property (p_deep_exit) else $error("deep sleep exit wrong");

  property p_pd_hold; // R26
    @(posedge ref_clk) disable iff (sys_rst)
      (in_pd && !clock_enable) |=> $stable(state);
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("power state moved without clock enable");

endmodule

// >>> tb/host_ctrl_model.sv
// Host controller model driving clock enable, select, command bits and termination pin
module host_ctrl_model (
  input  wire logic       ref_clk,
  output logic            clock_enable,
  output logic            chip_select_n,
  output logic [9:0]      command_address,
  output logic            termination_control_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus: deselected, clock enable high
  initial begin
    clock_enable = 1'h1;
    chip_select_n = 1'h1;
    command_address = 10'h000;
    termination_control_pin = 1'h0;
  end

  // Pin is asynchronous; wait out the synchroniser before anyone looks
  task automatic set_pin(input logic v);
    @(negedge ref_clk);
    termination_control_pin = v;
    repeat (7) @(negedge ref_clk);
  endtask

  // Entry command, then two no-operation cycles
  task automatic enter(input logic cs_n, input logic [2:0] ca);
    // Quiet gap stands in for write, refresh and register-write spacing
    repeat (2) @(negedge ref_clk);
    @(negedge ref_clk);
    clock_enable = 1'h0;
    chip_select_n = cs_n;
    command_address = {7'h00, ca};
    repeat (2) begin
      @(negedge ref_clk);
      chip_select_n = 1'h1;
      command_address = ~command_address;
    end
  endtask

  // Inputs are don't-care while low; toggle so stale values never look valid
  task automatic hold(input int n);
    repeat (n) begin
      @(negedge ref_clk);
      chip_select_n = ~chip_select_n;
      command_address = ~command_address;
    end
  endtask

  // Clock runs throughout, so it is stable well before exit
  task automatic leave();
    @(negedge ref_clk);
    clock_enable = 1'h1;
    chip_select_n = 1'h1;
  endtask
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for power-down and termination control
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BURST_LEN = 8;
  logic [5:0] read_latency;
  logic       ref_clk;
  logic       sys_rst;
  logic       clock_enable;
  logic       chip_select_n;
  logic [9:0] command_address;
  logic       termination_control_pin;
  logic [1:0] termination_setting_register;
  logic       pd_termination_enable;
  logic       read_issued;
  logic       write_leveling_mode;
  logic       read_dq_cal_active;
  logic       zq_cal_active;
  logic       ca_training_mode;
  logic       self_refresh_active;
  logic       banks_idle;
  logic       init_done;
  logic       dq_term_en;
  logic       dqs_term_en;
  logic       io_buffers_on;
  logic       receivers_on;
  logic       refresh_allowed;
  logic       cmd_ready;
  logic       active_power_down;
  logic       deep_sleep_state;
  logic       init_required;
  int         mismatches;
  int         samples_checked;

  // Device and its controller
  dram_powerdown_odt_control #(.BURST_LENGTH(BURST_LEN)) uut (.ref_clk, .sys_rst, .clock_enable,
    .chip_select_n, .command_address, .termination_control_pin, .termination_setting_register,
    .pd_termination_enable, .read_latency, .read_issued, .write_leveling_mode,
    .read_dq_cal_active, .zq_cal_active, .ca_training_mode, .self_refresh_active, .banks_idle,
    .init_done, .dq_term_en, .dqs_term_en, .io_buffers_on, .receivers_on, .refresh_allowed,
    .cmd_ready, .active_power_down, .deep_sleep_state, .init_required);
  host_ctrl_model host (.ref_clk, .clock_enable, .chip_select_n, .command_address,
    .termination_control_pin);

  // 200 MHz clock
  initial begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic seen, input logic exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %b seen %b", what, exp, seen);
    end
  endtask

  task automatic term(input logic dq, input logic dqs);
    check("dq_term_en", dq_term_en, dq);
    check("dqs_term_en", dqs_term_en, dqs);
  endtask

  task automatic give_verdict();
    if (mismatches == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Setting codes, pin level, write leveling and blocking modes
  task automatic t_modes();
    host.set_pin(1'h1);
    term(1'h0, 1'h0);
    for (int c = 1; c < 4; c++) begin
      termination_setting_register = 2'(c);
      repeat (2) @(negedge ref_clk);
      term(1'h1, 1'h1);
    end
    write_leveling_mode = 1'h1;
    repeat (2) @(negedge ref_clk);
    term(1'h0, 1'h1);
    host.set_pin(1'h0);
    term(1'h0, 1'h0);
    write_leveling_mode = 1'h0;
    host.set_pin(1'h1);
    for (int i = 0; i < 4; i++) begin
      {read_dq_cal_active, zq_cal_active, ca_training_mode, self_refresh_active} = 4'(1 << i);
      repeat (2) @(negedge ref_clk);
      term(1'h0, 1'h0);
    end
    {read_dq_cal_active, zq_cal_active, ca_training_mode, self_refresh_active} = 4'h0;
    repeat (2) @(negedge ref_clk);
  endtask

  // Read window; off from edge lat-2 after the read up to edge lat+burst/2
  task automatic t_read(input int lat);
    read_latency = 6'(lat);
    repeat (2) @(negedge ref_clk);
    read_issued = 1'h1;
    @(negedge ref_clk);
    read_issued = 1'h0;
    for (int n = 0; n <= lat + BURST_LEN / 2 + 2; n++) begin
      term(!(n >= lat - 2 && n < lat + BURST_LEN / 2),
           !(n >= lat - 2 && n < lat + BURST_LEN / 2));
      @(negedge ref_clk);
    end
  endtask

  // Power-down entry, noise while down, exit latency
  task automatic t_pd(input logic idle, input logic pden);
    banks_idle = idle;
    pd_termination_enable = pden;
    host.enter(1'h1, 3'h3);
    check("io_buffers_on", io_buffers_on, 1'h0);
    check("receivers_on", receivers_on, 1'h1);
    check("refresh_allowed", refresh_allowed, 1'h0);
    check("active_power_down", active_power_down, !idle);
    @(negedge ref_clk);
    check("receivers_on", receivers_on, 1'h0);
    term(pden, pden);
    host.hold(5);
    check("deep_sleep_state", deep_sleep_state, 1'h0);
    check("cmd_ready", cmd_ready, 1'h0);
    host.leave();
    @(negedge ref_clk);
    check("cmd_ready", cmd_ready, 1'h0);
    check("io_buffers_on", io_buffers_on, 1'h1);
    @(negedge ref_clk);
    check("cmd_ready", cmd_ready, 1'h1);
    @(negedge ref_clk);
    term(1'h1, 1'h1);
  endtask

  // Deep sleep entry, exit and re-initialisation flag
  task automatic t_deep();
    host.enter(1'h0, 3'h3);
    check("deep_sleep_state", deep_sleep_state, 1'h1);
    check("init_required", init_required, 1'h1);
    term(1'h0, 1'h0);
    host.hold(4);
    host.leave();
    @(negedge ref_clk);
    check("cmd_ready", cmd_ready, 1'h1);
    check("init_required", init_required, 1'h1);
    init_done = 1'h1;
    @(negedge ref_clk);
    init_done = 1'h0;
    check("init_required", init_required, 1'h0);
  endtask

  // Watchdog well past the expected run length
  initial begin
    repeat (3000) @(posedge ref_clk);
    mismatches++;
    give_verdict();
  end

  // Main sequence
  initial begin
    mismatches = 0;
    samples_checked = 0;
    sys_rst = 1'h1;
    termination_setting_register = 2'h0;
    pd_termination_enable = 1'h0;
    read_issued = 1'h0;
    read_latency = 6'h06;
    write_leveling_mode = 1'h0;
    {read_dq_cal_active, zq_cal_active, ca_training_mode, self_refresh_active} = 4'h0;
    banks_idle = 1'h1;
    init_done = 1'h0;
    repeat (4) @(negedge ref_clk);
    sys_rst = 1'h0;
    check("cmd_ready", cmd_ready, 1'h1);
    t_modes();
    t_read(6);
    t_read(2);
    t_pd(1'h1, 1'h0);
    t_pd(1'h0, 1'h1);
    t_deep();
    give_verdict();
  end
endmodule
